// >>> verilog/isa_dma_channel_controller.sv
// Seven-channel cascaded ISA DMA controller with its memory write buffer
`include "dma_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// Memory write buffer
module dma_fifo #(
  parameter int W = 41,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] fill_r;
  logic push;
  logic pop;

  // Honest full and empty from the fill count
  assign in_ready = (fill_r != (AW+1)'(D));
  assign out_valid = (fill_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rp_r];

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      fill_r <= '0;
    end else begin
      if (push) wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      if (pop) rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      fill_r <= fill_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) mem_r[wp_r] <= in_data;
  end
endmodule

module isa_dma_channel_controller
  import dma_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // Configuration I/O cycles from the PCI target decode
  input wire logic IO_STB,
  input wire logic IO_WR,
  input wire logic [15:0] IO_ADDR,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  output logic IO_ACK,
  // ISA DMA handshake, bit 4 unused
  input wire logic [7:0] DREQ,
  output logic [7:0] DACK_N,
  input wire logic EOP_N,
  // ISA command strobes and data
  output logic IOR_N,
  output logic IOW_N,
  output logic MEMR_N,
  output logic MEMW_N,
  input wire logic IOCHRDY,
  input wire logic [15:0] ISA_DIN,
  output logic [15:0] ISA_DOUT,
  output logic ISA_DOE,
  // PCI bus ownership
  output logic PCI_REQ_N,
  input wire logic PCI_GNT_N,
  // Memory write stream
  output logic MEM_WVALID,
  input wire logic MEM_WREADY,
  output var mem_wr_t MEM_WR,
  // Memory read
  output logic MEM_RREQ,
  output logic [23:0] MEM_RADDR,
  output logic MEM_RWIDE,
  input wire logic MEM_RVALID,
  input wire logic [15:0] MEM_RDATA,
  // Controller states
  output ctrl_state_t BYTE_STATE,
  output ctrl_state_t WORD_STATE
);
  localparam int FW = $bits(mem_wr_t);

  // Pin synchronisers
  logic [25:0] sync1_r;
  logic [25:0] sync2_r;
  logic [7:0] dreq_s;
  logic eop_n_s;
  logic rdy_s;
  logic [15:0] din_s;

  // Configuration space
  logic [7:0] index_r;
  logic [7:0] mode_r [8];
  logic [15:0] base_addr_r [8];
  logic [15:0] cur_addr_r [8];
  logic [15:0] base_cnt_r [8];
  logic [15:0] cur_cnt_r [8];
  logic [7:0] page_r [8];
  logic [7:0] mask_r;
  logic [7:0] tc_r;
  logic [7:0] rdata_r;
  logic ack_r;

  // Engine
  phase_t phase_r;
  logic [2:0] cur_ch_r;
  logic [1:0] wpri_r;
  logic [1:0] bpri_r;
  logic [5:0] cnt_r;
  logic [7:0] dack_r;
  logic [23:0] xaddr_r;
  logic [15:0] dout_r;
  logic doe_r;
  logic yield_r;
  ctrl_state_t byte_state_r;
  ctrl_state_t word_state_r;

  logic cfg_hit;
  logic data_wr;
  logic [7:0] pend;
  logic byte_any;
  logic [2:0] bp;
  logic [2:0] wp;
  logic [2:0] sel;
  chan_mode_t cm;
  chan_mode_t sm;
  logic wide;
  logic done_strobe;
  logic tc_now;
  logic next_upd;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [FW-1:0] fifo_out;
  mem_wr_t push_word;

  // Rotating pick among four requests, starting after the last served
  function automatic logic [2:0] pick4(input logic [3:0] req, input logic [1:0] last);
    logic [2:0] res;
    logic [1:0] k;
    res = 3'b000;
    for (int i = 4; i >= 1; i--) begin
      k = last + i[1:0];
      if (req[k]) res = {1'b1, k};
    end
    return res;
  endfunction

  // Strobe width in cycles for the selected timing type
  function automatic logic [5:0] cycles(input timing_t t);
    logic [5:0] c;
    c = 6'(`TYPE_A_CYC);
    if (t == TM_B) c = 6'(`TYPE_B_CYC);
    else if (t == TM_F) c = 6'(`TYPE_F_CYC);
    return c;
  endfunction

  // Two flops on every ISA pin input before any logic looks at it
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {IOCHRDY, EOP_N, DREQ, ISA_DIN};
      sync2_r <= sync1_r;
    end
  end
  assign {rdy_s, eop_n_s, dreq_s, din_s} = sync2_r;

  // Request arbitration: byte controller feeds channel 4 of the word one
  assign pend = dreq_s & ~mask_r;
  assign byte_any = |pend[3:0];
  assign bp = pick4(pend[3:0], bpri_r);
  assign wp = pick4({pend[7:5], byte_any}, wpri_r);
  assign sel = (wp[1:0] == 2'b00) ? {1'b0, bp[1:0]} : {1'b1, wp[1:0]};
  assign sm = chan_mode_t'(mode_r[sel]);
  assign cm = chan_mode_t'(mode_r[cur_ch_r]);
  assign wide = cur_ch_r[2];

  // Configuration decode
  assign cfg_hit = IO_STB && (IO_ADDR == `CFG_INDEX_PORT || IO_ADDR == `CFG_DATA_PORT);
  assign data_wr = IO_STB && IO_WR && (IO_ADDR == `CFG_DATA_PORT);

  // Transfer completion terms
  assign done_strobe = (phase_r == PH_STROBE) && (cnt_r <= 6'h01) && rdy_s;
  assign tc_now = (cur_cnt_r[cur_ch_r] <= 16'h0001) || !eop_n_s;
  assign next_upd = (phase_r == PH_NEXT);
  assign fifo_in_valid = done_strobe && (cm.xtype == XT_WRITE);
  assign push_word = '{addr: xaddr_r, wide: wide, data: wide ? din_s : {8'h00, din_s[7:0]}};

  // Index port and registered read answer
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      index_r <= 8'h00;
      rdata_r <= 8'h00;
      ack_r <= 1'b0;
    end else begin
      ack_r <= cfg_hit;
      if (IO_STB && IO_WR && IO_ADDR == `CFG_INDEX_PORT) index_r <= IO_WDATA;
      rdata_r <= 8'h00;
      if (IO_STB && !IO_WR && IO_ADDR == `CFG_DATA_PORT) begin
        if (index_r[7:3] == `IDX_MODE_HI) rdata_r <= mode_r[index_r[2:0]];
        else if (index_r == `IDX_MASK) rdata_r <= mask_r;
        else if (index_r == `IDX_STATUS) rdata_r <= tc_r;
        else if (index_r == `IDX_STATE) rdata_r <= {4'h0, word_state_r, byte_state_r};
        else if (index_r[7:6] == `IDX_CHAN_HI) begin
          case (index_r[2:0])
            `SUB_ADDR_LO: rdata_r <= cur_addr_r[index_r[5:3]][7:0];
            `SUB_ADDR_HI: rdata_r <= cur_addr_r[index_r[5:3]][15:8];
            `SUB_PAGE: rdata_r <= page_r[index_r[5:3]];
            `SUB_CNT_LO: rdata_r <= cur_cnt_r[index_r[5:3]][7:0];
            `SUB_CNT_HI: rdata_r <= cur_cnt_r[index_r[5:3]][15:8];
            default: rdata_r <= 8'h00;
          endcase
        end
      end
    end
  end

  // Mask and terminal-count flags; hardware set wins over software
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      mask_r <= `MASK_RESET;
      tc_r <= 8'h00;
    end else begin
      mask_r <= ((data_wr && index_r == `IDX_MASK) ? IO_WDATA : mask_r)
        | ((next_upd && tc_now && !cm.autoinit) ? 8'(8'h01 << cur_ch_r) : 8'h00);
      tc_r <= ((data_wr && index_r == `IDX_STATUS) ? (tc_r & ~IO_WDATA) : tc_r)
        | ((next_upd && tc_now) ? 8'(8'h01 << cur_ch_r) : 8'h00);
    end
  end

  // Channel register file: software writes and per-transfer updates
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < 8; i++) begin
        mode_r[i] <= (i == 4) ? `MODE_CASCADE_CH : `MODE_RESET;
        base_addr_r[i] <= 16'h0000;
        cur_addr_r[i] <= 16'h0000;
        base_cnt_r[i] <= 16'h0000;
        cur_cnt_r[i] <= 16'h0000;
        page_r[i] <= 8'h00;
      end
    end else begin
      if (data_wr && index_r[7:3] == `IDX_MODE_HI) begin
        // Channel 4 stays locked to cascade
        if (index_r[2:0] == `CASCADE_CH) mode_r[index_r[2:0]] <= `MODE_CASCADE_CH;
        else mode_r[index_r[2:0]] <= IO_WDATA;
      end else if (data_wr && index_r[7:6] == `IDX_CHAN_HI) begin
        // Base writes also load the working copies
        case (index_r[2:0])
          `SUB_ADDR_LO: begin
            base_addr_r[index_r[5:3]][7:0] <= IO_WDATA;
            cur_addr_r[index_r[5:3]][7:0] <= IO_WDATA;
          end
          `SUB_ADDR_HI: begin
            base_addr_r[index_r[5:3]][15:8] <= IO_WDATA;
            cur_addr_r[index_r[5:3]][15:8] <= IO_WDATA;
          end
          `SUB_PAGE: page_r[index_r[5:3]] <= IO_WDATA;
          `SUB_CNT_LO: begin
            base_cnt_r[index_r[5:3]][7:0] <= IO_WDATA;
            cur_cnt_r[index_r[5:3]][7:0] <= IO_WDATA;
          end
          `SUB_CNT_HI: begin
            base_cnt_r[index_r[5:3]][15:8] <= IO_WDATA;
            cur_cnt_r[index_r[5:3]][15:8] <= IO_WDATA;
          end
          default: ;
        endcase
      end
      if (next_upd) begin
        if (tc_now && cm.autoinit) begin
          cur_addr_r[cur_ch_r] <= base_addr_r[cur_ch_r];
          cur_cnt_r[cur_ch_r] <= base_cnt_r[cur_ch_r];
        end else begin
          cur_addr_r[cur_ch_r] <= cur_addr_r[cur_ch_r] + 16'h0001;
          cur_cnt_r[cur_ch_r] <= cur_cnt_r[cur_ch_r] - 16'h0001;
        end
      end
    end
  end

  // Transfer engine
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      phase_r <= PH_IDLE;
      cur_ch_r <= 3'h0;
      wpri_r <= 2'h3;
      bpri_r <= 2'h3;
      cnt_r <= 6'h00;
      dack_r <= 8'h00;
      xaddr_r <= 24'h000000;
      dout_r <= 16'h0000;
      doe_r <= 1'b0;
      yield_r <= 1'b0;
    end else begin
      // One idle cycle with the bus request released after a terminal count or a single-mode transfer
      yield_r <= 1'b0;
      case (phase_r)
        PH_IDLE: begin
          // A register access in the same cycle goes first
          if (!cfg_hit && wp[2] && !yield_r) begin
            phase_r <= PH_BUS;
            cur_ch_r <= sel;
          end
        end
        PH_BUS: begin
          // No acknowledge until the PCI bus is ours
          if (!PCI_GNT_N) begin
            if (wp[2]) begin
              cur_ch_r <= sel;
              dack_r <= 8'(8'h01 << sel);
              wpri_r <= wp[1:0];
              if (wp[1:0] == 2'b00) bpri_r <= bp[1:0];
              phase_r <= (sm.mode == XM_CASCADE) ? PH_CASCADE : PH_SETUP;
            end else begin
              phase_r <= PH_IDLE;
            end
          end
        end
        PH_SETUP: begin
          // Word channels count words, so the byte address doubles
          xaddr_r <= wide ? {page_r[cur_ch_r][7:1], cur_addr_r[cur_ch_r], 1'b0}
            : {page_r[cur_ch_r], cur_addr_r[cur_ch_r]};
          cnt_r <= cycles(cm.timing);
          if (cm.xtype == XT_READ) phase_r <= PH_MREAD;
          else if (cm.xtype != XT_WRITE || fifo_in_ready) phase_r <= PH_STROBE;
        end
        PH_MREAD: begin
          if (MEM_RVALID) begin
            dout_r <= wide ? MEM_RDATA : {8'h00, MEM_RDATA[7:0]};
            doe_r <= 1'b1;
            phase_r <= PH_STROBE;
          end
        end
        PH_STROBE: begin
          // Hold the strobes past their width while IOCHRDY is low
          if (cnt_r > 6'h01) cnt_r <= cnt_r - 6'h01;
          else if (rdy_s) begin
            doe_r <= 1'b0;
            phase_r <= PH_NEXT;
          end
        end
        PH_NEXT: begin
          if (tc_now || cm.mode == XM_SINGLE) begin
            dack_r <= 8'h00;
            yield_r <= 1'b1;
            phase_r <= PH_IDLE;
          end else if (cm.mode == XM_BLOCK) begin
            phase_r <= PH_SETUP;
          end else if (dreq_s[cur_ch_r]) begin
            phase_r <= PH_SETUP;
          end else begin
            dack_r <= 8'h00;
            phase_r <= PH_IDLE;
          end
        end
        PH_CASCADE: begin
          // External controller owns the cycles until it drops hold
          if (!pend[cur_ch_r]) begin
            dack_r <= 8'h00;
            phase_r <= PH_IDLE;
          end
        end
        default: phase_r <= PH_IDLE;
      endcase
    end
  end

  // Controller states seen by software
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      byte_state_r <= CS_IDLE;
      word_state_r <= CS_IDLE;
    end else begin
      if (phase_r != PH_IDLE) word_state_r <= CS_ACTIVE;
      else if (cfg_hit) word_state_r <= CS_PROGRAM;
      else word_state_r <= CS_IDLE;
      if (phase_r != PH_IDLE && !cur_ch_r[2]) byte_state_r <= CS_ACTIVE;
      else if (phase_r == PH_IDLE && cfg_hit) byte_state_r <= CS_PROGRAM;
      else byte_state_r <= CS_IDLE;
    end
  end

  // Memory write buffer; a full buffer stalls the engine before the strobe
  dma_fifo #(.W(FW), .D(`FIFO_DEPTH)) u_wbuf (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(MEM_WVALID),
    .out_ready(MEM_WREADY),
    .out_data(fifo_out)
  );
  assign MEM_WR = mem_wr_t'(fifo_out);

  // ISA strobes; verify cycles run the timing with no strobe
  assign IOR_N = !(phase_r == PH_STROBE && cm.xtype == XT_WRITE);
  assign MEMW_N = !(phase_r == PH_STROBE && cm.xtype == XT_WRITE);
  assign IOW_N = !(phase_r == PH_STROBE && cm.xtype == XT_READ);
  assign MEMR_N = !(phase_r == PH_STROBE && cm.xtype == XT_READ);

  // Bus request stays up while buffered writes remain; the yield cycle forces rearbitration
  assign PCI_REQ_N = !((phase_r != PH_IDLE || MEM_WVALID) && !yield_r);
  assign MEM_RREQ = (phase_r == PH_MREAD);
  assign MEM_RADDR = xaddr_r;
  assign MEM_RWIDE = wide;
  assign DACK_N = ~dack_r;
  assign ISA_DOUT = dout_r;
  assign ISA_DOE = doe_r;
  assign IO_RDATA = rdata_r;
  assign IO_ACK = ack_r;
  assign BYTE_STATE = byte_state_r;
  assign WORD_STATE = word_state_r;
endmodule

`default_nettype wire

// >>> verilog/dma_defs.svh
// Constant offsets, reset values and timing counts of the DMA channel controller
`ifndef DMA_DEFS_SVH
`define DMA_DEFS_SVH

// PCI I/O ports of the configuration space
`define CFG_INDEX_PORT 16'h0022
`define CFG_DATA_PORT 16'h0023

// Configuration space indices
`define IDX_MODE_HI 5'h00
`define IDX_MASK 8'h08
`define IDX_STATUS 8'h09
`define IDX_STATE 8'h0a
`define IDX_CHAN_HI 2'h1

// Per-channel sub-register selectors
`define SUB_ADDR_LO 3'h0
`define SUB_ADDR_HI 3'h1
`define SUB_PAGE 3'h2
`define SUB_CNT_LO 3'h3
`define SUB_CNT_HI 3'h4

// Reset values
`define MODE_RESET 8'h00
`define MODE_CASCADE_CH 8'h18
`define MASK_RESET 8'hff
`define CASCADE_CH 3'h4

// ISA cycle timing, least strobe widths in ns
`define CLK_PERIOD_NS 20
`define TYPE_A_NS 720
`define TYPE_B_NS 480
`define TYPE_F_NS 120
`define TYPE_A_CYC ((`TYPE_A_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TYPE_B_CYC ((`TYPE_B_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TYPE_F_CYC ((`TYPE_F_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Memory write buffer
`define FIFO_DEPTH 8

`endif

// >>> verilog/dma_pkg.sv
// Types shared by the DMA channel controller
`default_nettype none
package dma_pkg;
  typedef enum logic [1:0] {CS_IDLE = 2'b00, CS_PROGRAM = 2'b01, CS_ACTIVE = 2'b10} ctrl_state_t;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000, PH_BUS = 3'b001, PH_SETUP = 3'b010, PH_MREAD = 3'b011,
    PH_STROBE = 3'b100, PH_NEXT = 3'b101, PH_CASCADE = 3'b110
  } phase_t;
  typedef enum logic [1:0] {XT_VERIFY = 2'b00, XT_WRITE = 2'b01, XT_READ = 2'b10, XT_RSVD = 2'b11} xtype_t;
  typedef enum logic [1:0] {XM_DEMAND = 2'b00, XM_SINGLE = 2'b01, XM_BLOCK = 2'b10, XM_CASCADE = 2'b11} xmode_t;
  typedef enum logic [1:0] {TM_A = 2'b00, TM_B = 2'b01, TM_F = 2'b10, TM_RSVD = 2'b11} timing_t;
  typedef struct packed {
    logic spare;
    timing_t timing;
    xmode_t mode;
    logic autoinit;
    xtype_t xtype;
  } chan_mode_t;
  typedef struct packed {
    logic [23:0] addr;
    logic wide;
    logic [15:0] data;
  } mem_wr_t;
endpackage

`default_nettype wire

// >>> sim/dma_asserts.sv
// Port-level checks of the DMA channel controller
`include "dma_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dma_asserts
  import dma_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // Configuration cycles
  input wire logic IO_STB,
  input wire logic [15:0] IO_ADDR,
  input wire logic [7:0] IO_RDATA,
  input wire logic IO_ACK,
  // Handshake, strobes and bus ownership
  input wire logic [7:0] DACK_N,
  input wire logic IOR_N,
  input wire logic IOW_N,
  input wire logic MEMR_N,
  input wire logic MEMW_N,
  input wire logic PCI_REQ_N,
  input wire logic PCI_GNT_N,
  // Write stream and states
  input wire logic MEM_WVALID,
  input wire logic MEM_WREADY,
  input wire mem_wr_t MEM_WR,
  input wire ctrl_state_t BYTE_STATE,
  input wire ctrl_state_t WORD_STATE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  logic hit;
  // Access to either configuration port
  assign hit = IO_STB && (IO_ADDR == `CFG_INDEX_PORT || IO_ADDR == `CFG_DATA_PORT);

  a_cfg_ack: assert property (hit |=> IO_ACK)
    else $error("config access not acknowledged");
  a_ack_cause: assert property (IO_ACK |-> $past(hit))
    else $error("acknowledge without config access");
  a_rdata_idle: assert property (!IO_ACK |-> IO_RDATA == 8'h00)
    else $error("read data outside acknowledge");
  a_ack_after_gnt: assert property ((DACK_N != 8'hff && $past(DACK_N) == 8'hff)
    |-> !$past(PCI_GNT_N))
    else $error("acknowledge before bus grant");
  a_one_ack: assert property ($onehot0(~DACK_N) && DACK_N[4])
    else $error("more than one acknowledge");
  a_bus_held: assert property (DACK_N != 8'hff |-> !PCI_REQ_N)
    else $error("acknowledge without bus request");
  a_strobe_ack: assert property (!(IOR_N & IOW_N & MEMR_N & MEMW_N) |-> DACK_N != 8'hff)
    else $error("strobe without acknowledge");
  a_strobe_pair: assert property (IOR_N == MEMW_N && IOW_N == MEMR_N && (IOR_N || IOW_N))
    else $error("strobe pairing wrong");
  a_strobe_width: assert property ($fell(IOR_N & IOW_N) |-> (!(IOR_N & IOW_N)) [*6])
    else $error("strobe shorter than fastest timing");
  a_state_legal: assert property (BYTE_STATE != 2'b11 && WORD_STATE != 2'b11)
    else $error("illegal controller state");
  a_wr_hold: assert property (MEM_WVALID && !MEM_WREADY |=> MEM_WVALID && $stable(MEM_WR))
    else $error("write stream dropped while stalled");

  // Main scenarios reached
  c_cfg: cover property (hit);
  c_io_read: cover property ($fell(IOR_N));
  c_io_write: cover property ($fell(IOW_N));
  c_stall: cover property (MEM_WVALID && !MEM_WREADY);
endmodule
bind isa_dma_channel_controller dma_asserts i_chk (.CLOCK, .RESET_N, .IO_STB, .IO_ADDR,
  .IO_RDATA, .IO_ACK, .DACK_N, .IOR_N, .IOW_N, .MEMR_N, .MEMW_N, .PCI_REQ_N, .PCI_GNT_N,
  .MEM_WVALID, .MEM_WREADY, .MEM_WR, .BYTE_STATE, .WORD_STATE);
`default_nettype wire

// >>> sim/isa_periph.sv
// Behavioural ISA peripherals on the request and acknowledge side
`timescale 1ns/1ps
`default_nettype none
module isa_periph (
  // Clock, reset and scenario control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] want,
  input wire logic [3:0] wait_cyc,
  // Handshake and ISA bus
  output logic [7:0] dreq,
  input wire logic [7:0] dack_n,
  input wire logic ior_n,
  input wire logic iow_n,
  output logic iochrdy,
  output logic eop_n,
  output logic [15:0] din,
  input wire logic [15:0] dout,
  // Data taken on write strobes
  output logic got,
  output logic [15:0] got_d
);
  logic [7:0] n_r;
  logic [3:0] w_r;
  logic ior_q, iow_q;
  function automatic logic [15:0] pat(logic [7:0] k);
    return {k ^ 8'h5a, k};
  endfunction
  // Request held only while the device has work; cascade passes a hold request
  assign dreq = want;
  assign eop_n = 1'b1;
  assign iochrdy = (w_r == 4'h0);
  // Released data line shows the inverse of the last value, never a stale copy
  assign din = ior_n ? ~pat(n_r - 8'h01) : pat(n_r);
  // Not-ready stretch, transfer count and capture of written data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_r <= 4'h0;
      n_r <= 8'h00;
      ior_q <= 1'b1;
      iow_q <= 1'b1;
      got <= 1'b0;
      got_d <= 16'h0000;
    end else begin
      ior_q <= ior_n;
      iow_q <= iow_n;
      got <= !iow_q && iow_n;
      if (!iow_n) got_d <= dout;
      if (!ior_q && ior_n) n_r <= n_r + 8'h01;
      if ((ior_q & iow_q) && !(ior_n & iow_n)) w_r <= wait_cyc;
      else if (w_r != 4'h0) w_r <= w_r - 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench of the seven-channel DMA controller
`include "dma_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dma_pkg::*;
  logic CLOCK, RESET_N, IO_STB, IO_WR, IO_ACK, EOP_N, IOR_N, IOW_N, MEMR_N, MEMW_N, IOCHRDY;
  logic ISA_DOE, PCI_REQ_N, PCI_GNT_N, MEM_WVALID, MEM_WREADY, MEM_RREQ, MEM_RWIDE, MEM_RVALID;
  logic [15:0] IO_ADDR, ISA_DIN, ISA_DOUT, MEM_RDATA, got_d;
  logic [7:0] IO_WDATA, IO_RDATA, DREQ, DACK_N, want, q, v;
  logic [23:0] MEM_RADDR, ea;
  logic [31:0] seed, r, ar;
  logic [3:0] wait_cyc;
  logic [2:0] c;
  logic [1:0] rc;
  logic got;
  mem_wr_t MEM_WR, e;
  ctrl_state_t BYTE_STATE, WORD_STATE;
  int bad_count, check_count;
  mem_wr_t wq[$];
  logic [15:0] dq[$];
  logic [23:0] rq[$];

  isa_dma_channel_controller i_dut (.CLOCK, .RESET_N, .IO_STB, .IO_WR, .IO_ADDR, .IO_WDATA,
    .IO_RDATA, .IO_ACK, .DREQ, .DACK_N, .EOP_N, .IOR_N, .IOW_N, .MEMR_N, .MEMW_N, .IOCHRDY,
    .ISA_DIN, .ISA_DOUT, .ISA_DOE, .PCI_REQ_N, .PCI_GNT_N, .MEM_WVALID, .MEM_WREADY, .MEM_WR,
    .MEM_RREQ, .MEM_RADDR, .MEM_RWIDE, .MEM_RVALID, .MEM_RDATA, .BYTE_STATE, .WORD_STATE);
  isa_periph i_per (.clk(CLOCK), .rst_n(RESET_N), .want, .wait_cyc, .dreq(DREQ),
    .dack_n(DACK_N), .ior_n(IOR_N), .iow_n(IOW_N), .iochrdy(IOCHRDY), .eop_n(EOP_N),
    .din(ISA_DIN), .dout(ISA_DOUT), .got, .got_d);

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Memory contents are a function of the address, so reads are predictable
  function automatic logic [15:0] mdat(logic [23:0] a);
    return a[16:1] ^ 16'h3c3c;
  endfunction

  task automatic chk(string nm, logic [23:0] ex, logic [23:0] sn);
    check_count++;
    if (sn !== ex) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic conclude();
    if (bad_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One configuration cycle; the acknowledge must follow only the two ports
  task automatic io(logic w, logic [15:0] a, logic [7:0] d);
    @(posedge CLOCK);
    IO_STB <= 1'b1;
    IO_WR <= w;
    IO_ADDR <= a;
    IO_WDATA <= d;
    @(posedge CLOCK);
    IO_STB <= 1'b0;
    #1;
    q = IO_RDATA;
    chk("io_ack", {23'h0, a[15:1] == 15'h0011}, {23'h0, IO_ACK});
  endtask
  task automatic wr(logic [7:0] i, logic [7:0] d);
    io(1'b1, `CFG_INDEX_PORT, i);
    io(1'b1, `CFG_DATA_PORT, d);
  endtask
  task automatic rd(logic [7:0] i);
    io(1'b1, `CFG_INDEX_PORT, i);
    io(1'b0, `CFG_DATA_PORT, 8'h00);
  endtask
  task automatic prog(logic [2:0] ch, logic [7:0] md, logic [31:0] a, logic [15:0] n);
    wr({5'h0, ch}, md);
    wr({2'b01, ch, `SUB_ADDR_LO}, a[7:0]);
    wr({2'b01, ch, `SUB_ADDR_HI}, a[15:8]);
    wr({2'b01, ch, `SUB_PAGE}, a[23:16]);
    wr({2'b01, ch, `SUB_CNT_LO}, n[7:0]);
    wr({2'b01, ch, `SUB_CNT_HI}, n[15:8]);
  endtask
  // Wait for n data units, then for the engine to let go of the bus
  task automatic waitn(int n);
    for (int i = 0; i < 4000 && wq.size() + dq.size() < n; i++) @(posedge CLOCK);
    for (int i = 0; i < 300 && !(DACK_N === 8'hff && PCI_REQ_N === 1'b1); i++) @(posedge CLOCK);
  endtask

  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end
  initial begin
    repeat (20000) @(posedge CLOCK);
    bad_count++;
    conclude();
  end
  // Arbiter grants late at random; memory stalls writes and answers reads
  always @(posedge CLOCK) begin
    ar = xs();
    PCI_GNT_N <= PCI_REQ_N | ar[3];
    MEM_WREADY <= ar[7] | ar[9];
    if (MEM_WVALID && MEM_WREADY) wq.push_back(MEM_WR);
    if (got) dq.push_back(got_d);
    MEM_RVALID <= 1'b0;
    MEM_RDATA <= ~MEM_RDATA;
    rc <= (MEM_RREQ && !MEM_RVALID) ? rc + 2'd1 : 2'd0;
    if (rc == 2'd2) begin
      MEM_RVALID <= 1'b1;
      MEM_RDATA <= mdat(MEM_RADDR);
      rq.push_back(MEM_RADDR);
      rc <= 2'd0;
    end
  end

  initial begin
    seed = 32'd16;
    bad_count = 0;
    check_count = 0;
    {RESET_N, IO_STB, IO_WR, IO_ADDR, IO_WDATA, want, wait_cyc, rc} = '0;
    {PCI_GNT_N, MEM_WREADY, MEM_RVALID, MEM_RDATA} = {3'b100, 16'h0000};
    repeat (5) @(posedge CLOCK);
    RESET_N <= 1'b1;
    // Reset view of the configuration space, plus an unmapped port
    rd(`IDX_MASK);
    chk("mask", `MASK_RESET, q);
    rd(`IDX_STATE);
    chk("state", 8'h00, q);
    rd({5'h0, `CASCADE_CH});
    chk("casc_mode", `MODE_CASCADE_CH, q);
    io(1'b1, 16'h0024, 8'h5a);
    // All four modes, three types and three timings read back
    for (int m = 0; m < 12; m++) begin
      v = {1'b0, 2'(m % 3), 2'(m / 3), m[0], 2'(m % 3)};
      c = 3'(m % 7);
      if (c > 3'd3) c = c + 3'd1;
      wr({5'h0, c}, v);
      rd({5'h0, c});
      chk("mode", v, q);
    end
    // Byte channel 1, single write transfers with random wait states
    r = xs();
    prog(3'd1, 8'h49, r, 16'd2);
    wr(`IDX_MASK, 8'hed);
    @(posedge CLOCK);
    wait_cyc <= r[27:24];
    want <= 8'h02;
    waitn(2);
    want <= 8'h00;
    for (int k = 0; k < 2; k++) begin
      e = wq.pop_front();
      chk("wr_addr", {r[23:16], r[15:0] + 16'(k)}, e.addr);
      chk("wr_data", 24'(k), {16'h0, e.data[7:0]});
      chk("wr_wide", 24'h0, {23'h0, e.wide});
    end
    rd(`IDX_MASK);
    chk("mask_tc", 8'hef, q);
    rd(`IDX_STATUS);
    chk("tc_bit", 8'h02, q & 8'h02);
    wr(`IDX_STATUS, 8'hff);
    // Word channel 5, block read with autoinit and stalled requester drop
    r = xs();
    prog(3'd5, 8'h36, r, 16'd3);
    wr(`IDX_MASK, 8'hcf);
    @(posedge CLOCK);
    wait_cyc <= r[27:24];
    want <= 8'h20;
    // Block mode keeps going after the request drops
    for (int i = 0; i < 400 && DACK_N[5] !== 1'b0; i++) @(posedge CLOCK);
    want <= 8'h00;
    waitn(3);
    for (int k = 0; k < 3; k++) begin
      ea = {r[23:17], r[15:0] + 16'(k), 1'b0};
      chk("rd_addr", ea, rq.pop_front());
      chk("rd_data", mdat(ea), dq.pop_front());
    end
    rd(`IDX_MASK);
    chk("mask_auto", 8'hcf, q);
    rd({2'b01, 3'd5, `SUB_CNT_LO});
    chk("cnt_reload", 8'h03, q);
    rd({2'b01, 3'd5, `SUB_ADDR_LO});
    chk("addr_reload", r[7:0], q);
    // Channel 7 demand verify moves nothing but still counts out
    prog(3'd7, 8'h00, xs(), 16'd1);
    wr(`IDX_MASK, 8'h4f);
    @(posedge CLOCK);
    want <= 8'h80;
    for (int i = 0; i < 400 && DACK_N[7] !== 1'b0; i++) @(posedge CLOCK);
    waitn(0);
    want <= 8'h00;
    chk("verify_traffic", 24'h0, 24'(wq.size() + dq.size()));
    rd(`IDX_MASK);
    chk("mask_verify", 8'hcf, q);
    // Byte channel 0 cascade: hold request in, hold acknowledge out until it drops
    wr(8'h00, 8'h18);
    wr(`IDX_MASK, 8'hee);
    @(posedge CLOCK);
    want <= 8'h01;
    for (int i = 0; i < 400 && DACK_N[0] !== 1'b0; i++) @(posedge CLOCK);
    repeat (20) @(posedge CLOCK);
    chk("casc_ack", 24'hfe, {16'h0, DACK_N});
    want <= 8'h00;
    waitn(0);
    chk("casc_drop", 24'hff, {16'h0, DACK_N});
    conclude();
  end
endmodule
`default_nettype wire
